/* adcsq_top.sv */
`timescale 1ns/100ps
`include "adcsq_consts.svh"
// Functional notes
// - Writing start bit 0 to 1 begins a conversion on the selected channel.
// - Start bit stays set while busy, ignores writes of 0, cleared at end.
// - Done flag set at each completion; it is the interrupt request.
// - Repeat mode runs conversions back to back; otherwise one and stop.
// - Clearing repeat mode lets the current conversion finish, then halts.
// - With pin trigger enabled, a falling pin edge starts a conversion.
// - Qualify set: interrupt only when done and range match both set.
// - Range match flag updated at the end of every conversion.
// - Power bit needed; clearing it aborts and clears the start bit.
// - Outside select one matches outside the window, zero inside.
// - Upper byte format one gives bits 9:8 low, else bits 9:2.
// - Three-bit channel field picks the input for the next conversion.
// - Converter clock is machine clock divided by N plus one.
// - Lower result byte always returns result bits 7:0.
// - Limits compare against result bits 9:2.
// - All registers reset to zero, leaving the analog part off.
// - Sixteen converter clocks: five sample, ten approximate, done last.
// - Repeat mode restarts on the next machine cycle after completion.
// - Match equals outside xor (upper < res) xor (lower < res).
// - Interrupt reaches the core only with its enable; software clears.
module adcsq_top
    import adcsq_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Special-function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // External start pin, falling edge starts
    input  wire logic       ext_start_n,
    // Interrupt
    input  wire logic       conv_irq_enable,
    output logic            conv_irq,
    // Analog front end
    input  wire logic       cmp_above,
    output logic            analog_power_on,
    output logic            sample_hold,
    output logic      [2:0] conv_channel,
    output logic      [9:0] dac_code
);

    adcsq_state_t st;
    adcsq_state_t next_st;

    logic       start_busy;
    logic       eoc;
    logic       repeat_mode;
    logic       pin_trigger_enable;
    logic       range_irq_qualify;
    logic       range_match_flag;
    logic       range_outside_select;
    logic [7:0] ctl_b;
    logic [7:0] win_hi;
    logic [7:0] win_lo;
    logic [9:0] result;
    logic [9:0] mask;
    logic [3:0] stp;
    logic [4:0] tick_seen;

    // Decode
    wire wr_a  = sfr_wr && (sfr_addr == `ADCSQ_OFS_CTL_A);
    wire wr_b  = sfr_wr && (sfr_addr == `ADCSQ_OFS_CTL_B);
    wire wr_hi = sfr_wr && (sfr_addr == `ADCSQ_OFS_WIN_HI);
    wire wr_lo = sfr_wr && (sfr_addr == `ADCSQ_OFS_WIN_LO);

    wire       upper_byte_format   = ctl_b[`ADCSQ_B_FORMAT];
    wire [2:0] channel_select      =
        ctl_b[`ADCSQ_B_CHAN_HI:`ADCSQ_B_CHAN_LO];
    wire [3:0] clock_divide_select =
        ctl_b[`ADCSQ_B_DIV_HI:`ADCSQ_B_DIV_LO];

    wire pin_fall;
    wire tick;

    wire abort    = wr_a && !sfr_wdata[`ADCSQ_A_POWER];
    wire power_now = wr_a ? sfr_wdata[`ADCSQ_A_POWER] : analog_power_on;

    // software start on 0 to 1
    wire sw_start = wr_a && sfr_wdata[`ADCSQ_A_BUSY];
    wire pin_start = pin_fall && pin_trigger_enable;
    wire start_go  = (sw_start || pin_start) && power_now && !start_busy;

    // done on the sixteenth converter clock
    wire done    = tick && start_busy && (st == ST_DONE);
    wire restart = done && repeat_mode;

    wire match_now = range_outside_select
                   ^ (win_hi < dac_code[9:2])
                   ^ (win_lo < dac_code[9:2]);

    wire [7:0] rd_upper = upper_byte_format
                        ? {6'h00, result[9:8]} : result[9:2];
    wire [7:0] rd_lower = result[7:0];
    wire [7:0] rd_ctl_a = {start_busy, eoc, repeat_mode,
                           pin_trigger_enable, range_irq_qualify,
                           range_match_flag, analog_power_on,
                           range_outside_select};
    wire [7:0] rd_mux =
        (sfr_addr == `ADCSQ_OFS_CTL_A)  ? rd_ctl_a :
        (sfr_addr == `ADCSQ_OFS_CTL_B)  ? ctl_b    :
        (sfr_addr == `ADCSQ_OFS_RES_HI) ? rd_upper :
        (sfr_addr == `ADCSQ_OFS_RES_LO) ? rd_lower :
        (sfr_addr == `ADCSQ_OFS_WIN_HI) ? win_hi   :
        (sfr_addr == `ADCSQ_OFS_WIN_LO) ? win_lo   : `ADCSQ_RST_BYTE;

    assign conv_irq = conv_irq_enable && eoc
                    && (!range_irq_qualify || range_match_flag);
    assign sample_hold = (st == ST_SAMPLE);

    adcsq_pin_sync u_pin (
        .clk  (clk),
        .rst  (rst),
        .pin  (ext_start_n),
        .fall (pin_fall)
    );

    // Prescaler is held clear while idle so each start is aligned
    // Each tick already restarts the count, so no clear on restart;
    // gating by restart would loop back through tick
    adcsq_prescaler u_div (
        .clk  (clk),
        .rst  (rst),
        .clr  (!start_busy),
        .div  (clock_divide_select),
        .tick (tick)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_b  <= `ADCSQ_RST_BYTE;
            win_hi <= `ADCSQ_RST_BYTE;
            win_lo <= `ADCSQ_RST_BYTE;
        end else begin
            if (wr_b)  ctl_b  <= sfr_wdata;
            if (wr_hi) win_hi <= sfr_wdata;
            if (wr_lo) win_lo <= sfr_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            repeat_mode          <= 1'b0;
            pin_trigger_enable   <= 1'b0;
            range_irq_qualify    <= 1'b0;
            analog_power_on      <= 1'b0;
            range_outside_select <= 1'b0;
        end else if (wr_a) begin
            repeat_mode          <= sfr_wdata[`ADCSQ_A_REPEAT];
            pin_trigger_enable   <= sfr_wdata[`ADCSQ_A_PINTRIG];
            range_irq_qualify    <= sfr_wdata[`ADCSQ_A_QUALIFY];
            analog_power_on      <= sfr_wdata[`ADCSQ_A_POWER];
            range_outside_select <= sfr_wdata[`ADCSQ_A_OUTSIDE];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_busy <= 1'b0;
        end else if (abort) begin
            start_busy <= 1'b0;
        end else if (start_go) begin
            start_busy <= 1'b1;
        end else if (done && !repeat_mode) begin
            start_busy <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eoc              <= 1'b0;
            range_match_flag <= 1'b0;
        end else if (done) begin
            eoc              <= 1'b1;
            range_match_flag <= match_now;
        end else if (wr_a) begin
            eoc              <= sfr_wdata[`ADCSQ_A_EOC];
            range_match_flag <= sfr_wdata[`ADCSQ_A_MATCH];
        end
    end

    always_comb begin
        next_st = st;
        if (abort) begin
            next_st = ST_IDLE;
        end else if (start_go) begin
            next_st = ST_SAMPLE;
        end else if (tick) begin
            unique case (st)
                ST_IDLE: begin
                    next_st = ST_IDLE;
                end
                ST_SAMPLE: begin
                    if (stp == `ADCSQ_SAMPLE_LAST) next_st = ST_APPROX;
                end
                ST_APPROX: begin
                    if (stp == `ADCSQ_APPROX_LAST) next_st = ST_DONE;
                end
                ST_DONE: begin
                    next_st = repeat_mode ? ST_SAMPLE : ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stp <= 4'h0;
        end else if (abort || start_go || restart) begin
            stp <= 4'h0;
        end else if (tick) begin
            stp <= stp + 4'h1;
        end
    end

    // Trial bit is set, then kept only if the comparator says
    // the DAC is still below the input
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dac_code <= 10'h000;
            mask     <= 10'h000;
        end else if (abort || start_go || restart) begin
            dac_code <= 10'h000;
            mask     <= 10'h000;
        end else if (tick && st == ST_SAMPLE
                     && stp == `ADCSQ_SAMPLE_LAST) begin
            dac_code <= `ADCSQ_SAR_MSB;
            mask     <= `ADCSQ_SAR_MSB;
        end else if (tick && st == ST_APPROX) begin
            dac_code <= (cmp_above ? dac_code : (dac_code & ~mask))
                      | (mask >> 1);
            mask     <= mask >> 1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result       <= 10'h000;
            conv_channel <= 3'h0;
        end else begin
            if (done) result <= dac_code;
            if (start_go || restart) conv_channel <= channel_select;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= `ADCSQ_RST_BYTE;
        end else begin
            sfr_rdata <= rd_mux;
        end
    end

    // Helper: converter clocks since start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_seen <= 5'h00;
        end else if (start_go || restart) begin
            tick_seen <= 5'h00;
        end else if (tick) begin
            tick_seen <= tick_seen + 5'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_sw_start;
        sw_start && power_now && !start_busy;
    endsequence

    sequence s_busy_on;
        start_busy && (stp == 4'h0) && (st == ST_SAMPLE);
    endsequence

    a_sw_start_busy: assert property (
        s_sw_start |=> s_busy_on)
        else $error("software start did not begin a conversion");

    a_busy_holds: assert property (
        start_busy && !abort && !done |=> start_busy)
        else $error("busy dropped before conversion end");

    a_eoc_on_done: assert property (
        done |=> eoc && (result == $past(dac_code)))
        else $error("completion did not set done flag and result");

    a_repeat_keeps: assert property (
        done && repeat_mode && !abort |=> s_busy_on)
        else $error("repeat mode did not restart at once");

    a_single_stops: assert property (
        done && !repeat_mode && !abort
        |=> !start_busy && (st == ST_IDLE)
            ##1 (!start_busy || $past(start_go)))
        else $error("single shot did not halt");

    a_pin_start: assert property (
        pin_start && power_now && !start_busy |=> s_busy_on)
        else $error("pin edge did not start a conversion");

    a_irq_qualify: assert property (
        conv_irq |-> eoc && (range_match_flag || !range_irq_qualify))
        else $error("interrupt raised without its qualifiers");

    a_match_value: assert property (
        done |=> range_match_flag == $past(match_now))
        else $error("range match flag not updated at end");

    a_abort_clears: assert property (
        abort |=> !start_busy && (st == ST_IDLE))
        else $error("power off did not abort the conversion");

    a_sixteen_clks: assert property (
        done |-> (tick_seen == 5'h0f) && (stp == `ADCSQ_CONV_LAST))
        else $error("conversion did not take sixteen clocks");

    a_upper_fmt: assert property (
        upper_byte_format && !done && (sfr_addr == `ADCSQ_OFS_RES_HI)
        |=> (sfr_rdata == {6'h00, result[9:8]}))
        else $error("upper byte format wrong");

endmodule // adcsq_top

/* adcsq_consts.svh */
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH

// Register offsets in the special-function space
`define ADCSQ_OFS_CTL_A    8'hb2
`define ADCSQ_OFS_CTL_B    8'hb3
`define ADCSQ_OFS_RES_HI   8'hb4
`define ADCSQ_OFS_RES_LO   8'hb5
`define ADCSQ_OFS_WIN_HI   8'hb6
`define ADCSQ_OFS_WIN_LO   8'hb7

// Reset value of every register
`define ADCSQ_RST_BYTE     8'h00

// Control register A bit positions
`define ADCSQ_A_BUSY       7
`define ADCSQ_A_EOC        6
`define ADCSQ_A_REPEAT     5
`define ADCSQ_A_PINTRIG    4
`define ADCSQ_A_QUALIFY    3
`define ADCSQ_A_MATCH      2
`define ADCSQ_A_POWER      1
`define ADCSQ_A_OUTSIDE    0

// Control register B fields
`define ADCSQ_B_FORMAT     7
`define ADCSQ_B_CHAN_HI    6
`define ADCSQ_B_CHAN_LO    4
`define ADCSQ_B_DIV_HI     3
`define ADCSQ_B_DIV_LO     0

// Step counter values that end each conversion phase; first trial code
`define ADCSQ_SAMPLE_LAST  4'h4
`define ADCSQ_APPROX_LAST  4'he
`define ADCSQ_CONV_LAST    4'hf
`define ADCSQ_SAR_MSB      10'h200

// Machine clocks software waits after power on; plain default
`define ADCSQ_WARMUP_CLKS  8'h08

`endif

/* adcsq_pkg.sv */
package adcsq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_APPROX = 2'b10,
        ST_DONE   = 2'b11
    } adcsq_state_t;

endpackage

/* adcsq_prescaler.sv */
`timescale 1ns/100ps
module adcsq_prescaler (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Control
    input  wire logic       clr,
    input  wire logic [3:0] div,
    // Converter clock pulse
    output logic            tick
);

    logic [3:0] cnt;
    logic [4:0] gap;

    // Converter clock is machine clock over div plus one
    // divide by N+1
    assign tick = !clr && (cnt == div);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 4'h0;
        end else if (clr || tick) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end

    // Helper for the period check only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap <= 5'h00;
        end else if (clr || tick) begin
            gap <= 5'h00;
        end else begin
            gap <= gap + 5'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_tick_period: assert property (
        tick |-> (gap == {1'b0, div}))
        else $error("converter clock period is not div plus one");

endmodule // adcsq_prescaler

/* adcsq_pin_sync.sv */
`timescale 1ns/100ps
module adcsq_pin_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Raw pin and falling edge pulse
    input  wire logic pin,
    output logic      fall
);

    logic meta;
    logic sync;
    logic last;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b1;
            sync <= 1'b1;
            last <= 1'b1;
        end else begin
            meta <= pin;
            sync <= meta;
            last <= sync;
        end
    end

    assign fall = last && !sync;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_one_fall: assert property (
        fall |=> !fall)
        else $error("one pin edge gave two start pulses");

endmodule // adcsq_pin_sync

/* adcsq_top_tb.sv */
`timescale 1ns/100ps
`include "adcsq_consts.svh"
module adcsq_top_tb
    import adcsq_pkg::*;
;
    logic       clk;
    logic       rst;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic       ext_start_n;
    logic       conv_irq_enable;
    logic       conv_irq;
    logic       cmp_above;
    logic       analog_power_on;
    logic       sample_hold;
    logic [2:0] conv_channel;
    logic [9:0] dac_code;
    logic [9:0] vin;
    logic       sh_q;
    logic [7:0] rv;
    int         mismatches;
    int         n_tests;
    int         n_starts;
    int         n_samp;

    adcsq_top u_dut (
        .clk             (clk),
        .rst             (rst),
        .sfr_addr        (sfr_addr),
        .sfr_wr          (sfr_wr),
        .sfr_wdata       (sfr_wdata),
        .sfr_rdata       (sfr_rdata),
        .ext_start_n     (ext_start_n),
        .conv_irq_enable (conv_irq_enable),
        .conv_irq        (conv_irq),
        .cmp_above       (cmp_above),
        .analog_power_on (analog_power_on),
        .sample_hold     (sample_hold),
        .conv_channel    (conv_channel),
        .dac_code        (dac_code)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Comparator model lags one edge, so prescale must be at least 1
    always @(posedge clk) begin
        cmp_above <= (dac_code <= vin);
        sh_q      <= sample_hold;
        if (sample_hold === 1'b1) n_samp++;
        if (sample_hold === 1'b1 && sh_q !== 1'b1) n_starts++;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_addr <= a;
        @(posedge clk);
        @(negedge clk);
        d = sfr_rdata;
        @(posedge clk);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 3000; i++) begin
            rd(8'hb2, rv);
            if (rv[7] === 1'b0) return;
        end
        mismatches++;
        $display("wrong value busy wait expected 0 seen 1");
        finish_test();
    endtask

    task automatic t_reset();
        for (int a = 8'hb2; a <= 8'hb8; a++) begin
            rd(a[7:0], rv);
            chk("reset byte", 8'h00, rv);
        end
        chk("power pin", 8'h00, {7'h0, analog_power_on});
    endtask

    task automatic t_conv(logic [9:0] v, logic [7:0] hi, logic [7:0] lo,
                          logic q, logic o, logic [2:0] ch, logic [3:0] dv,
                          logic fmt);
        logic m;
        int   s;
        m = o ^ (hi < v[9:2]) ^ (lo < v[9:2]);
        vin <= v;
        wr(8'hb6, hi);
        wr(8'hb7, lo);
        wr(8'hb3, {fmt, ch, dv});
        wr(8'hb2, {4'h0, q, 1'b0, 1'b1, o});
        repeat (`ADCSQ_WARMUP_CLKS) @(posedge clk);
        s = n_samp;
        wr(8'hb2, {4'h8, q, 1'b0, 1'b1, o});
        wr(8'hb2, {4'h0, q, 1'b0, 1'b1, o});
        rd(8'hb2, rv);
        chk("busy held", 8'h01, {7'h0, rv[7]});
        chk("channel", {5'h0, ch}, {5'h0, conv_channel});
        wait_idle();
        chk("sample clocks", 8'(5 * (dv + 1)), 8'(n_samp - s));
        rd(8'hb2, rv);
        chk("ctl a", {4'h4, q, m, 1'b1, o}, rv);
        rd(8'hb4, rv);
        chk("upper", fmt ? {6'h0, v[9:8]} : v[9:2], rv);
        rd(8'hb5, rv);
        chk("lower", v[7:0], rv);
        chk("irq", {7'h0, !q || m}, {7'h0, conv_irq});
        conv_irq_enable <= 1'b0;
        @(posedge clk);
        chk("irq masked", 8'h00, {7'h0, conv_irq});
        conv_irq_enable <= 1'b1;
        wr(8'hb2, 8'h02);
        chk("irq cleared", 8'h00, {7'h0, conv_irq});
    endtask

    task automatic t_repeat();
        int s;
        vin <= 10'h155;
        wr(8'hb3, 8'h21);
        s = n_starts;
        wr(8'hb2, 8'ha2);
        for (int i = 0; i < 500 && n_starts < s + 3; i++) @(posedge clk);
        chk("restarts", 8'd3, 8'(n_starts - s));
        if (n_starts - s != 3) finish_test();
        rd(8'hb2, rv);
        chk("busy steady", 8'h01, {7'h0, rv[7]});
        wr(8'hb2, 8'h82);
        s = n_starts;
        wait_idle();
        repeat (40) @(posedge clk);
        chk("halt after", 8'h00, 8'(n_starts - s));
        rd(8'hb5, rv);
        chk("repeat lower", 8'h55, rv);
    endtask

    task automatic t_pin();
        int s;
        wr(8'hb2, 8'h02);
        ext_start_n <= 1'b0;
        repeat (8) @(posedge clk);
        rd(8'hb2, rv);
        chk("pin ignored", 8'h00, {7'h0, rv[7]});
        ext_start_n <= 1'b1;
        repeat (4) @(posedge clk);
        wr(8'hb2, 8'h12);
        s = n_starts;
        ext_start_n <= 1'b0;
        repeat (6) @(posedge clk);
        rd(8'hb2, rv);
        chk("pin start", 8'h01, {7'h0, rv[7]});
        wait_idle();
        repeat (40) @(posedge clk);
        chk("one per edge", 8'h01, 8'(n_starts - s));
        ext_start_n <= 1'b1;
        @(posedge clk);
    endtask

    task automatic t_abort();
        wr(8'hb2, 8'h82);
        repeat (10) @(posedge clk);
        wr(8'hb2, 8'h00);
        rd(8'hb2, rv);
        chk("abort", 8'h00, rv);
        chk("power off", 8'h00, {7'h0, analog_power_on});
        chk("no sample", 8'h00, {7'h0, sample_hold});
        wr(8'hb2, 8'h80);
        rd(8'hb2, rv);
        chk("no start", 8'h00, {7'h0, rv[7]});
    endtask

    initial begin
        rst             = 1'b1;
        sfr_addr        = 8'h00;
        sfr_wr          = 1'b0;
        sfr_wdata       = 8'h00;
        ext_start_n     = 1'b1;
        conv_irq_enable = 1'b1;
        vin             = 10'h000;
        mismatches      = 0;
        n_tests         = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_conv(10'h2a5, 8'hc0, 8'h80, 1'b1, 1'b0, 3'h5, 4'h1, 1'b0);
        t_conv(10'h3ff, 8'hc0, 8'h80, 1'b1, 1'b0, 3'h7, 4'h3, 1'b1);
        t_conv(10'h004, 8'h01, 8'h00, 1'b0, 1'b1, 3'h0, 4'h2, 1'b0);
        t_repeat();
        t_pin();
        t_abort();
        finish_test();
    end
endmodule // adcsq_top_tb
